// File: core/fbost_tracker.sv
/*
 * Per-bank output state tracker with a small command interface
 * sequencer, buffered factory program exit detection and illegal
 * command classification.
 * Assumes host write strobes and busy are on core_clk (logic, not pins).
 * The host raises wr_valid for one edge per command; writes may come
 * back to back on consecutive edges.
 * A read sees the bank state one edge after rd_bank changes, because
 * the read kind is registered.
 * Every bank starts from array output after reset.
 */
// Behaviour
// - Read of command bank uses its state.
// - Four states: array, status, signature, query.
// - Each bank changes only on own command.
// - Sequencing ignores the bank output state.
// - Lock/OTP setup cycles ignored while busy.
// - FFFFh to other block exits factory program.
// - Undefined codes take the illegal path.
`timescale 1ns/1ns
`include "fbost_params.svh"
module fbost_tracker
    import fbost_pkg::*;
#(
    parameter int BANKS    = 16,  // Number of banks.
    parameter int BANK_W   = 4,   // Bank address width.
    parameter int BLOCK_W  = 7    // Block address width.
) (
    input  wire logic               core_clk,     // System clock, 10 MHz.
    input  wire logic               srst,         // Synchronous reset, active high.
    input  wire logic               clk_en,       // Freezes all state while low.
    input  wire logic               wr_valid,     // One-cycle command write strobe.
    input  wire logic [15:0]        wr_data,      // Written data word.
    input  wire logic [BANK_W-1:0]  wr_bank,      // Bank of the write address.
    input  wire logic [BLOCK_W-1:0] wr_block,     // Block of the write address.
    input  wire logic               pec_done,     // Controller finished an operation.
    input  wire logic [BANK_W-1:0]  rd_bank,      // Bank being read.
    output logic [1:0]              rd_kind,      // Data kind driven on the read.
    output logic                    rd_own_state, // Read hits the last command bank.
    output logic                    pec_active,   // Controller busy.
    output logic                    buffered_factory_program_mode,    // Buffered factory program running.
    output logic                    buffered_factory_program_exit,    // One-cycle pulse on factory program exit.
    output logic                    illegal_seen  // Last command was illegal.
);
    // Whole module state in one record.
    // One record makes reset and freeze a single assignment each.
    typedef struct packed {
        fbost_ci_t                ci;          // Command interface state.
        logic [BANKS-1:0][1:0]    bank_out;    // Output state of every bank.
        logic [BANK_W-1:0]        last_bank;   // Bank of most recent command.
        logic [BLOCK_W-1:0]       first_block; // First block used in factory program.
        logic                     exit_pulse;  // Registered exit pulse.
        logic                     illegal;     // Last command was illegal.
        logic [1:0]               kind;        // Registered read kind.
        logic                     own;         // Registered bank hit.
    } fbost_state_t;

    fbost_state_t st;       // Current state.
    fbost_state_t next_st;  // Next state.
    fbost_cmd_if  cmd ();   // Classified current command.
    logic         busy_or_susp; // Controller busy or suspended.

    // Classify the written code.
    // Only the low byte is decoded; the full word matters for the exit.
    fbost_decode fbost_decode_inst (
        .code (wr_data[7:0]),
        .cmd  (cmd)
    );

    // Compute the next state of everything.
    // A command write moves the command state, the addressed bank, the
    // last-bank pointer and the illegal flag (first_block on a factory start);
    // the exit pulse clears and the read kind and hit flag follow every cycle.
    always_comb begin
        // Start from the held state so untouched fields keep their value.
        next_st            = st;
        // The exit pulse lasts one cycle unless it is set again below.
        next_st.exit_pulse = 1'b0;
        // A suspended operation still holds the controller.
        busy_or_susp       = (st.ci == FBOST_BUSY) || (st.ci == FBOST_SUSP);

        // Sequencing reads ci, the write, first_block and pec_done, never bank_out.
        if (wr_valid) begin
            // The effect of a taken write depends on the command state.
            unique case (st.ci)
                // Factory program streams data words; only the exit word acts.
                FBOST_BUFFERED_FACTORY_PROGRAM: begin
                    // Exit only on FFFFh to a different block.
                    // All ones to the first block is ordinary program data.
                    if (wr_data == `FBOST_BUFFERED_FACTORY_PROGRAM_EXIT_DATA && wr_block != st.first_block) begin
                        // Back to ready; the exit bank shows the array again.
                        next_st.ci         = FBOST_READY;
                        next_st.exit_pulse = 1'b1;
                        next_st.bank_out[wr_bank] = `FBOST_OUT_ARRAY;
                        next_st.last_bank  = wr_bank;
                    end
                end

                // The controller owns the array; reads still switch the output.
                FBOST_BUSY, FBOST_SUSP: begin
                    // Lock/OTP setup cycles are ignored entirely.
                    // Dropping them keeps a running operation undisturbed.
                    if (!cmd.is_lock_setup) begin
                        // The write still names the most recent command bank.
                        next_st.last_bank = wr_bank;
                        next_st.illegal   = cmd.is_illegal;
                        if (cmd.is_setup) begin
                            next_st.bank_out[wr_bank] = `FBOST_OUT_STATUS;
                        end else if (cmd.is_read_array) begin
                            next_st.bank_out[wr_bank] = `FBOST_OUT_ARRAY;
                        end else if (cmd.is_read_status) begin
                            next_st.bank_out[wr_bank] = `FBOST_OUT_STATUS;
                        end else if (cmd.is_read_sig) begin
                            next_st.bank_out[wr_bank] = `FBOST_OUT_SIG;
                        end else if (cmd.is_read_query) begin
                            next_st.bank_out[wr_bank] = `FBOST_OUT_QUERY;
                        end
                        // Other codes leave the output unchanged.
                        // Suspend and resume move between busy and suspended.
                        if (cmd.is_suspend && st.ci == FBOST_BUSY) begin
                            next_st.ci = FBOST_SUSP;
                        end else if (cmd.is_confirm && st.ci == FBOST_SUSP) begin
                            next_st.ci = FBOST_BUSY;
                        end
                    end
                end

                // Waiting for the second cycle of a command pair.
                FBOST_SETUP, FBOST_LOCKSET: begin
                    // Second cycle: lock setup needs a lock confirm, else illegal; other setups start an operation unless 80h.
                    next_st.last_bank = wr_bank;
                    next_st.bank_out[wr_bank] = `FBOST_OUT_STATUS;
                    next_st.illegal   = 1'b0;
                    // A lock or setting confirm completes at once.
                    if (st.ci == FBOST_LOCKSET && cmd.is_lock_conf) begin
                        next_st.ci = FBOST_READY;
                    end else if (st.ci == FBOST_LOCKSET) begin
                        // Any other code after a lock setup is refused.
                        next_st.ci      = FBOST_ILLEGAL;
                        next_st.illegal = 1'b1;
                    end else if (wr_data[7:0] == `FBOST_CMD_BUFFERED_FACTORY_PROGRAM_SETUP) begin
                        // Factory program cannot start as a second cycle.
                        next_st.ci = FBOST_ILLEGAL;
                    end else begin
                        // Program data or a confirm starts the controller.
                        next_st.ci = FBOST_BUSY;
                    end
                end

                // Ready, or after an illegal code: this is a first cycle.
                FBOST_READY, FBOST_ILLEGAL: begin
                    next_st.last_bank = wr_bank;
                    next_st.illegal   = cmd.is_illegal;
                    // An undefined code parks the sequencer until the next command.
                    if (cmd.is_illegal) begin
                        next_st.ci = FBOST_ILLEGAL;
                    end else if (cmd.is_lock_setup) begin
                        // Lock setup waits for its confirm.
                        next_st.ci = FBOST_LOCKSET;
                        next_st.bank_out[wr_bank] = `FBOST_OUT_STATUS;
                    end else if (wr_data[7:0] == `FBOST_CMD_BUFFERED_FACTORY_PROGRAM_SETUP) begin
                        next_st.ci          = FBOST_BUFFERED_FACTORY_PROGRAM;
                        // Remember the block that the exit must differ from.
                        next_st.first_block = wr_block;
                        next_st.bank_out[wr_bank] = `FBOST_OUT_STATUS;
                    end else if (cmd.is_setup) begin
                        next_st.ci = FBOST_SETUP;
                        next_st.bank_out[wr_bank] = `FBOST_OUT_STATUS;
                    end else begin
                        // Read commands select the output state.
                        next_st.ci = FBOST_READY;
                        if (cmd.is_read_array) begin
                            next_st.bank_out[wr_bank] = `FBOST_OUT_ARRAY;
                        end else if (cmd.is_read_sig) begin
                            next_st.bank_out[wr_bank] = `FBOST_OUT_SIG;
                        end else if (cmd.is_read_query) begin
                            next_st.bank_out[wr_bank] = `FBOST_OUT_QUERY;
                        end else if (cmd.is_read_status || cmd.is_blank_conf) begin
                            // Blank check confirm also shows status.
                            next_st.bank_out[wr_bank] = `FBOST_OUT_STATUS;
                        end
                    end
                end

                // A code that is not one-hot recovers to ready.
                default: begin
                    next_st.ci = FBOST_READY;
                end
            endcase
        end else if (pec_done && st.ci == FBOST_BUSY) begin
            // Completion returns to ready; output state unchanged.
            // Completion is looked at only in cycles without a write.
            next_st.ci = FBOST_READY;
        end

        // Read kind follows the read bank's state; hit flag marks the command bank.
        // Both are registered, so they trail rd_bank by one edge.
        next_st.kind = st.bank_out[rd_bank];
        next_st.own  = (rd_bank == st.last_bank);
    end

    // Register the state record.
    // Reset acts even while the clock enable is low; a low enable freezes all.
    // The whole record moves in one assignment.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st <= '{ci: FBOST_READY, bank_out: '0, last_bank: '0, first_block: '0,
                    exit_pulse: 1'b0, illegal: 1'b0, kind: `FBOST_OUT_ARRAY, own: 1'b0};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // Outputs taken from the state record.
    // pec_active stays low while an operation is suspended.
    assign rd_kind      = st.kind;
    assign rd_own_state = st.own;
    assign pec_active   = busy_or_susp && (st.ci == FBOST_BUSY);
    assign buffered_factory_program_mode    = (st.ci == FBOST_BUFFERED_FACTORY_PROGRAM);
    assign buffered_factory_program_exit    = st.exit_pulse;
    assign illegal_seen = st.illegal;
endmodule : fbost_tracker

// File: inc/fbost_params.svh
/*
 * Constants for the bank output state tracker: command codes, the
 * factory program exit word and output state codes.
 * Assumes it is included by bare name from design files.
 */
`ifndef FBOST_PARAMS_SVH
`define FBOST_PARAMS_SVH

// Command codes as seen on the low data byte.
`define FBOST_CMD_READ_ARRAY    8'hFF
`define FBOST_CMD_READ_STATUS  8'h70
`define FBOST_CMD_READ_SIG     8'h90
`define FBOST_CMD_READ_QUERY   8'h98
`define FBOST_CMD_CLR_STATUS   8'h50
`define FBOST_CMD_PROG_SETUP   8'h40
`define FBOST_CMD_PROG_ALT     8'h10
`define FBOST_CMD_BUF_PROG     8'hE8
`define FBOST_CMD_BUFFERED_FACTORY_PROGRAM_SETUP   8'h80
`define FBOST_CMD_ERASE_SETUP  8'h20
`define FBOST_CMD_CONFIRM      8'hD0
`define FBOST_CMD_SUSPEND      8'hB0
`define FBOST_CMD_LOCK_SETUP   8'h60
`define FBOST_CMD_BLANK_SETUP  8'hBC
`define FBOST_CMD_OTP_SETUP    8'hC0
`define FBOST_CMD_BLANK_CONF   8'hCB
`define FBOST_CMD_LOCK_CONF    8'h01
`define FBOST_CMD_LDOWN_CONF   8'h2F
`define FBOST_CMD_SETREG_CONF  8'h03
// Data word that ends buffered factory program.
`define FBOST_BUFFERED_FACTORY_PROGRAM_EXIT_DATA   16'hFFFF
// Output state codes held per bank.
`define FBOST_OUT_ARRAY        2'h0
`define FBOST_OUT_STATUS       2'h1
`define FBOST_OUT_SIG          2'h2
`define FBOST_OUT_QUERY        2'h3

`endif

// File: inc/fbost_pkg.sv
/*
 * Types for the bank output state tracker.
 * Assumes fbost_params.svh is available on the include path.
 */
package fbost_pkg;
    // Output data kinds a bank can drive.
    typedef enum logic [1:0] {
        FBOST_ARRAY  = 2'h0,
        FBOST_STATUS = 2'h1,
        FBOST_SIG    = 2'h2,
        FBOST_QUERY  = 2'h3
    } fbost_out_t;

    // Command interface states, one-hot.
    typedef enum logic [6:0] {
        FBOST_READY   = 7'h01,
        FBOST_SETUP   = 7'h02,
        FBOST_BUSY    = 7'h04,
        FBOST_SUSP    = 7'h08,
        FBOST_LOCKSET = 7'h10,
        FBOST_BUFFERED_FACTORY_PROGRAM    = 7'h20,
        FBOST_ILLEGAL = 7'h40
    } fbost_ci_t;
endpackage : fbost_pkg

// File: inc/fbost_cmd_if.sv
/*
 * Interface carrying a classified command from the front end decoder
 * to the tracker core.
 * Assumes both ends share core_clk.
 */
`timescale 1ns/1ns
interface fbost_cmd_if;
    logic       is_read_array;   // Read array command.
    logic       is_read_status;  // Read status command.
    logic       is_read_sig;     // Read signature command.
    logic       is_read_query;   // Read query command.
    logic       is_setup;        // Any setup command.
    logic       is_lock_setup;   // Lock/setting or OTP setup (two-cycle group).
    logic       is_lock_conf;    // Confirm of lock or setting register.
    logic       is_blank_conf;   // Blank check confirm.
    logic       is_confirm;      // Program/erase confirm or resume.
    logic       is_suspend;      // Suspend command.
    logic       is_clear;        // Clear status command.
    logic       is_illegal;      // Code outside the defined set.

    modport dec  (output is_read_array, is_read_status, is_read_sig, is_read_query, is_setup,
                  is_lock_setup, is_lock_conf, is_blank_conf, is_confirm, is_suspend,
                  is_clear, is_illegal);
    modport core (input  is_read_array, is_read_status, is_read_sig, is_read_query, is_setup,
                  is_lock_setup, is_lock_conf, is_blank_conf, is_confirm, is_suspend,
                  is_clear, is_illegal);
endinterface : fbost_cmd_if

// File: core/fbost_decode.sv
/*
 * Command code classifier for the command front end.
 * Assumes a code on the low data byte; purely combinational.
 */
`timescale 1ns/1ns
`include "fbost_params.svh"
module fbost_decode
    import fbost_pkg::*;
(
    input  wire logic [7:0] code,  // Command code written by the host.
    fbost_cmd_if.dec        cmd    // Classified command.
);
    // Classify the code; anything not matched is illegal.
    always_comb begin
        cmd.is_read_array  = (code == `FBOST_CMD_READ_ARRAY);
        cmd.is_read_status = (code == `FBOST_CMD_READ_STATUS);
        cmd.is_read_sig    = (code == `FBOST_CMD_READ_SIG);
        cmd.is_read_query  = (code == `FBOST_CMD_READ_QUERY);
        cmd.is_lock_setup  = (code == `FBOST_CMD_LOCK_SETUP) || (code == `FBOST_CMD_OTP_SETUP);
        cmd.is_setup       = cmd.is_lock_setup || (code == `FBOST_CMD_PROG_SETUP) ||
                             (code == `FBOST_CMD_PROG_ALT) || (code == `FBOST_CMD_BUF_PROG) ||
                             (code == `FBOST_CMD_BUFFERED_FACTORY_PROGRAM_SETUP) || (code == `FBOST_CMD_ERASE_SETUP) ||
                             (code == `FBOST_CMD_BLANK_SETUP);
        cmd.is_lock_conf   = (code == `FBOST_CMD_LOCK_CONF) || (code == `FBOST_CMD_LDOWN_CONF) ||
                             (code == `FBOST_CMD_SETREG_CONF);
        cmd.is_blank_conf  = (code == `FBOST_CMD_BLANK_CONF);
        cmd.is_confirm     = (code == `FBOST_CMD_CONFIRM);
        cmd.is_suspend     = (code == `FBOST_CMD_SUSPEND);
        cmd.is_clear       = (code == `FBOST_CMD_CLR_STATUS);
        // Codes outside the set take the illegal path.
        cmd.is_illegal     = !(cmd.is_read_array || cmd.is_read_status || cmd.is_read_sig ||
                               cmd.is_read_query || cmd.is_setup || cmd.is_lock_conf ||
                               cmd.is_blank_conf || cmd.is_confirm || cmd.is_suspend ||
                               cmd.is_clear);
    end
endmodule : fbost_decode

// File: bench/fbost_props.sv
/*
 * Concurrent checks on the ports of the bank output state tracker.
 * Assumes it is bound to fbost_tracker and sees only that module's ports.
 */
`timescale 1ns/1ns
module fbost_props #(
    parameter int BANK_W  = 4,  // Bank address width.
    parameter int BLOCK_W = 7   // Block address width.
) (
    input wire logic               core_clk,
    input wire logic               srst,
    input wire logic               clk_en,
    input wire logic               wr_valid,
    input wire logic [15:0]        wr_data,
    input wire logic [BANK_W-1:0]  wr_bank,
    input wire logic [BLOCK_W-1:0] wr_block,
    input wire logic               pec_done,
    input wire logic [BANK_W-1:0]  rd_bank,
    input wire logic [1:0]         rd_kind,
    input wire logic               rd_own_state,
    input wire logic               pec_active,
    input wire logic               buffered_factory_program_mode,
    input wire logic               buffered_factory_program_exit,
    input wire logic               illegal_seen
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (srst);

    // The first write after reset meets a known ready command state.
    sequence s_fresh(logic [7:0] c);
        $past(srst) && clk_en && wr_valid && wr_data[7:0] == c;
    endsequence
    // Two cycles without writes or completions let any pipeline stage settle.
    sequence s_quiet;
        (!wr_valid && !pec_done) [*2];
    endsequence

    AST_EXIT_ONE_CYCLE: assert property (buffered_factory_program_exit |=> !buffered_factory_program_exit)
        else $error("exit pulse lasts more than one cycle");
    AST_EXIT_LEAVES_MODE: assert property (buffered_factory_program_exit |-> !buffered_factory_program_mode && $past(buffered_factory_program_mode))
        else $error("exit pulse without leaving factory program");
    AST_EXIT_CAUSE: assert property (buffered_factory_program_exit |-> $past(wr_valid && wr_data == 16'hFFFF)
        || $past(wr_valid && wr_data == 16'hFFFF, 2)) else $error("exit pulse without an all-ones write");
    AST_LOCK_IGNORED: assert property (pec_active && clk_en && wr_valid
        && (wr_data[7:0] == 8'h60 || wr_data[7:0] == 8'hC0) |=> pec_active && $stable(illegal_seen))
        else $error("setup cycle acted on while busy");
    AST_QUIET_HOLDS: assert property (s_quiet |=> $stable(illegal_seen) && $stable(buffered_factory_program_mode)
        && $stable(pec_active)) else $error("state moved without a command");
    AST_FRESH_READ: assert property (s_fresh(8'h98) ##0 rd_bank == wr_bank |-> ##[2:3] rd_kind == 2'h3)
        else $error("read of command bank missed query data");
    AST_FRESH_ILLEGAL: assert property (s_fresh(8'h77) |-> ##[1:2] illegal_seen)
        else $error("undefined code not flagged");
    AST_BUSY_END: assert property (pec_active && pec_done && clk_en && !wr_valid |-> ##[1:2] !pec_active)
        else $error("busy did not end on completion");
    AST_FREEZE_HOLDS: assert property (!clk_en |=> $stable(rd_kind) && $stable(rd_own_state)
        && $stable(illegal_seen) && $stable(pec_active) && $stable(buffered_factory_program_mode) && $stable(buffered_factory_program_exit))
        else $error("state moved while the clock enable was low");
endmodule : fbost_props

// File: bench/fbost_host.sv
/*
 * Host controller model that writes command cycles to the tracker.
 * Assumes the caller invokes issue just after a rising edge of core_clk.
 */
`timescale 1ns/1ns
module fbost_host (
    input  wire logic core_clk,
    output logic        wr_valid,
    output logic [15:0] wr_data,
    output logic [3:0]  wr_bank,
    output logic [6:0]  wr_block
);
    // Bus starts idle.
    initial begin
        wr_valid = 1'b0;
        wr_data  = 16'h0000;
        wr_bank  = 4'h0;
        wr_block = 7'h00;
    end
    // One write: strobe for one edge, then one idle edge with the inverse word so stale data never matches.
    task automatic issue(input logic [15:0] d, input logic [3:0] bk, input logic [6:0] blk);
        wr_valid <= 1'b1;
        wr_data  <= d;
        wr_bank  <= bk;
        wr_block <= blk;
        @(posedge core_clk);
        wr_valid <= 1'b0;
        wr_data  <= ~d;
        @(posedge core_clk);
    endtask : issue
endmodule : fbost_host

// File: bench/test_flash_bank_output_state_tracker.sv
/*
 * Self-checking bench for the bank output state tracker.
 * Assumes fbost_host writes commands and fbost_props is bound below.
 */
`timescale 1ns/1ns
module test_flash_bank_output_state_tracker;
    logic        core_clk, srst, clk_en, pec_done;        // Bench-driven controls.
    logic [3:0]  rd_bank, b, wr_bank;                     // Read bank, random base, write bank.
    logic [15:0] wr_data;                                 // Written word.
    logic [6:0]  wr_block;                                // Write block.
    logic        wr_valid, pec_active, buffered_factory_program_mode, buffered_factory_program_exit, illegal_seen, rd_own_state;
    logic [1:0]  rd_kind;                                 // Data kind of the read bank.
    int          fails, n_checks, n_exit, i;              // Counters.
    integer      seed;                                    // Random seed.
    logic [2:0]  q_sel[$];                                // Which output each note checks.
    logic [7:0]  q_val[$];                                // Expected value of each note.
    logic [7:0]  codes[4];                                // Read command per output kind.

    fbost_host fbost_host_inst (.core_clk(core_clk), .wr_valid(wr_valid), .wr_data(wr_data),
        .wr_bank(wr_bank), .wr_block(wr_block));
    fbost_tracker #(.BANKS(16), .BANK_W(4), .BLOCK_W(7)) fbost_tracker_inst (.core_clk(core_clk),
        .srst(srst), .clk_en(clk_en), .wr_valid(wr_valid), .wr_data(wr_data), .wr_bank(wr_bank),
        .wr_block(wr_block), .pec_done(pec_done), .rd_bank(rd_bank), .rd_kind(rd_kind),
        .rd_own_state(rd_own_state), .pec_active(pec_active), .buffered_factory_program_mode(buffered_factory_program_mode),
        .buffered_factory_program_exit(buffered_factory_program_exit), .illegal_seen(illegal_seen));

    // Clock of 100 ns period.
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    // Compares a read data kind.
    task automatic cmp_kind(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: read kind %0h, wanted %0h", $time, got, exp);
        end
    endtask : cmp_kind
    // Compares a one-bit status output.
    task automatic cmp_flag(input logic [2:0] s, input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: flag %0d is %b, wanted %b", $time, s, got, exp);
        end
    endtask : cmp_flag
    // Queues an expectation for the watcher, then lets one edge pass.
    task automatic note(input logic [2:0] s, input logic [7:0] v);
        q_sel.push_back(s);
        q_val.push_back(v);
        @(posedge core_clk);
    endtask : note
    // Selects a bank for reading, lets the registered kind follow, then queues it.
    task automatic see_kind(input logic [3:0] bk, input logic [1:0] k);
        rd_bank <= bk;
        @(posedge core_clk);
        note(3'h0, {6'h00, k});
    endtask : see_kind
    // Holds reset for five edges with the read bank set.
    task automatic restart(input logic [3:0] bk);
        srst    <= 1'b1;
        rd_bank <= bk;
        repeat (5) @(posedge core_clk);
        srst    <= 1'b0;
    endtask : restart

    // Watcher: takes the oldest note and compares it at the settled falling edge.
    always @(negedge core_clk) begin
        if (buffered_factory_program_exit === 1'b1) n_exit++;
        if (q_sel.size() > 0) begin
            case (q_sel[0])
                3'h0:    cmp_kind(rd_kind, q_val[0][1:0]);
                3'h1:    cmp_flag(3'h1, illegal_seen, q_val[0][0]);
                3'h2:    cmp_flag(3'h2, pec_active, q_val[0][0]);
                3'h3:    cmp_flag(3'h3, buffered_factory_program_mode, q_val[0][0]);
                3'h4:    cmp_flag(3'h4, n_exit == 1, q_val[0][0]);
                default: cmp_flag(3'h5, rd_own_state, q_val[0][0]);
            endcase
            void'(q_sel.pop_front());
            void'(q_val.pop_front());
        end
    end
    // Watchdog well beyond the hundred or so cycles the tests need.
    initial begin
        #(3000 * 100);
        fails++;
        conclude();
    end

    // Main sequence.
    initial begin
        seed = 32'h9704;
        {srst, clk_en, pec_done} = 3'b110;
        rd_bank = 4'h0;
        fails = 0;
        n_checks = 0;
        n_exit = 0;
        codes = '{8'hFF, 8'h70, 8'h90, 8'h98};
        b = 4'($random(seed));
        // Every read command on its own bank; the first bank must keep its kind.
        restart(b);
        fbost_host_inst.issue(16'h0098, b, 7'h00);
        for (i = 0; i < 4; i++) fbost_host_inst.issue({8'($random(seed)), codes[i]}, b + 4'(i + 1), 7'h00);
        for (i = 0; i < 4; i++) see_kind(b + 4'(i + 1), 2'(i));
        see_kind(b, 2'h3);
        // A write while the clock enable is low must change nothing.
        clk_en <= 1'b0;
        fbost_host_inst.issue(16'h0070, b, 7'h00);
        clk_en <= 1'b1;
        see_kind(b, 2'h3);
        note(3'h5, 8'h00);
        // Busy controller: lock and one-time setup ignored, other setup selects status.
        restart(b);
        fbost_host_inst.issue(16'h0090, 4'h5, 7'h00);
        fbost_host_inst.issue(16'h0040, 4'h7, 7'h00);
        fbost_host_inst.issue(16'h1234, 4'h7, 7'h00);
        note(3'h2, 8'h01);
        fbost_host_inst.issue(16'h0060, 4'h5, 7'h00);
        fbost_host_inst.issue(16'h00C0, 4'h5, 7'h00);
        see_kind(4'h5, 2'h2);
        note(3'h1, 8'h00);
        fbost_host_inst.issue(16'h0020, 4'h6, 7'h00);
        see_kind(4'h6, 2'h1);
        pec_done <= 1'b1;
        @(posedge core_clk);
        pec_done <= 1'b0;
        @(posedge core_clk);
        note(3'h2, 8'h00);
        // Undefined codes, alone and as a bad lock confirm.
        restart(b);
        fbost_host_inst.issue(16'h0077, b, 7'h00);
        note(3'h1, 8'h01);
        restart(b);
        fbost_host_inst.issue(16'h0060, b, 7'h00);
        fbost_host_inst.issue(16'h0055, b, 7'h00);
        note(3'h1, 8'h01);
        // Factory program: all ones to the first block stays, to another block exits.
        restart(b);
        n_exit = 0;
        fbost_host_inst.issue(16'h0090, 4'h1, 7'h05);
        fbost_host_inst.issue(16'h0080, 4'h1, 7'h05);
        fbost_host_inst.issue(16'hFFFF, 4'h1, 7'h05);
        note(3'h3, 8'h01);
        fbost_host_inst.issue(16'hFFFF, 4'h1, 7'h06);
        note(3'h4, 8'h01);
        note(3'h3, 8'h00);
        see_kind(4'h1, 2'h0);
        note(3'h5, 8'h01);
        conclude();
    end
endmodule : test_flash_bank_output_state_tracker

bind fbost_tracker fbost_props #(.BANK_W(BANK_W), .BLOCK_W(BLOCK_W)) fbost_props_inst (.core_clk(core_clk),
    .srst(srst), .clk_en(clk_en), .wr_valid(wr_valid), .wr_data(wr_data), .wr_bank(wr_bank),
    .wr_block(wr_block), .pec_done(pec_done), .rd_bank(rd_bank), .rd_kind(rd_kind),
    .rd_own_state(rd_own_state), .pec_active(pec_active), .buffered_factory_program_mode(buffered_factory_program_mode),
    .buffered_factory_program_exit(buffered_factory_program_exit), .illegal_seen(illegal_seen));
